// ---- pme_event_status.v ----
// Per-port MAC event bookkeeping: pending events, mask, source summary,
// activity/link latch for the LED machine and CPU, and error counters.
// Assumes event inputs are one-cycle pulses synchronous to sys_clk, level
// inputs are already synchronous, and an APB master drives the bus.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pme_map.vh"

module pme_event_status #(
  parameter CNT8_W = 8,
  parameter CNT16_W = 16,
  parameter LEN_W = 16
) (
  input wire sys_clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Event sources
  input wire fabric_enable,
  input wire rx_pause_enable,
  input wire tx_underflow_evt,
  input wire tx_crc_err_evt,
  input wire tx_crc_from_rx,
  input wire rx_phy_err_evt,
  input wire pause_overflow_evt,
  input wire rx_crc_err_evt,
  input wire rx_runt_evt,
  input wire rx_frame_start,
  input wire rx_word_lost_evt,
  input wire rx_frame_end,
  input wire [LEN_W-1:0] rx_frame_len,
  input wire rx_frame_crc_bad,
  input wire [LEN_W-1:0] max_frame_length,
  input wire rx_overflow_discard_evt,
  input wire tx_underflow_frame_evt,
  input wire corrupted_frame_evt,
  // Other event registers of the port logic block
  input wire pcs_source_pending,
  input wire serdes_source_pending,
  // Activity and link levels
  input wire tx_active,
  input wire receiving_indication,
  input wire link_up_indication,
  input wire remote_fault_indication,
  input wire sync_loss_indication,
  // LED state machine read port
  input wire led_read,
  output reg [`PME_ACT_W-1:0] led_status,
  // Port interrupt, level
  output reg port_irq
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [CNT16_W-1:0] sat_inc;
  input [CNT16_W-1:0] val;
  input [CNT16_W-1:0] top;
  begin
    if (val == top) begin
      sat_inc = val;
    end else begin
      sat_inc = val + {{(CNT16_W-1){1'b0}}, 1'b1};
    end
  end
endfunction

localparam [CNT16_W-1:0] TOP8 = {{(CNT16_W-CNT8_W){1'b0}}, {CNT8_W{1'b1}}};
localparam [CNT16_W-1:0] TOP16 = {CNT16_W{1'b1}};

// APB handshake states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WAIT = 3'b010;
localparam [2:0] ST_DONE = 3'b100;

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [2:0] state_ff, nxt_state;
reg [`PME_EV_W-1:0] pending_ff, nxt_pending;
reg [`PME_EV_W-1:0] mask_ff, nxt_mask;
reg [`PME_ACT_W-1:0] activity_ff, nxt_activity;
reg [CNT8_W-1:0] ovf_cnt_ff, nxt_ovf_cnt;
reg [CNT8_W-1:0] unf_cnt_ff, nxt_unf_cnt;
reg [CNT16_W-1:0] corrupt_cnt_ff, nxt_corrupt_cnt;
reg [CNT16_W-1:0] jabber_cnt_ff, nxt_jabber_cnt;
reg fab_en_d_ff;
reg pause_en_d_ff;
reg lost_seen_ff, nxt_lost_seen;
reg [31:0] rdata_ff, nxt_rdata;
reg ready_ff, nxt_ready;
reg err_ff, nxt_err;
reg irq_ff, nxt_irq;
reg [`PME_ACT_W-1:0] led_ff, nxt_led;

always @* begin
  prdata = rdata_ff;
  pready = ready_ff;
  pslverr = err_ff;
  port_irq = irq_ff;
  led_status = led_ff;
end

////////////////////////////////////////////////////////////////////////////////
// Event detection

wire fab_fall = fab_en_d_ff & ~fabric_enable;
wire pause_fall = pause_en_d_ff & ~rx_pause_enable;
wire oversized = rx_frame_end & (rx_frame_len > max_frame_length);
wire jabber_evt = oversized & rx_frame_crc_bad;
wire word_lost_first = rx_word_lost_evt & ~lost_seen_ff;

reg [`PME_EV_W-1:0] ev_set;
always @* begin
  ev_set = {`PME_EV_W{1'b0}};
  ev_set[`PME_EV_FABRIC] = fab_fall;
  ev_set[`PME_EV_PAUSE_DROP] = pause_fall;
  ev_set[`PME_EV_TX_UNDERFLOW] = tx_underflow_evt;
  ev_set[`PME_EV_TX_ONLY_CRC] = tx_crc_err_evt & ~tx_crc_from_rx;
  ev_set[`PME_EV_TX_CRC] = tx_crc_err_evt;
  ev_set[`PME_EV_PHY_ERR] = rx_phy_err_evt;
  ev_set[`PME_EV_PAUSE_OVF] = pause_overflow_evt;
  ev_set[`PME_EV_OVERSIZED] = oversized;
  ev_set[`PME_EV_RX_CRC] = rx_crc_err_evt;
  ev_set[`PME_EV_OVERFLOW] = word_lost_first;
  ev_set[`PME_EV_RUNT] = rx_runt_evt;
end

// Once per frame: a new frame start re-arms the overflow flag
always @* begin
  nxt_lost_seen = lost_seen_ff;
  if (rx_frame_start) begin
    nxt_lost_seen = 1'b0;
  end
  if (rx_word_lost_evt) begin
    nxt_lost_seen = 1'b1;
  end
end

reg [`PME_ACT_W-1:0] act_set;
always @* begin
  act_set = {`PME_ACT_W{1'b0}};
  act_set[`PME_ACT_TRANSMITTING] = tx_active;
  act_set[`PME_ACT_RECEIVING] = receiving_indication;
  act_set[`PME_ACT_LINK_UP] = link_up_indication;
  act_set[`PME_ACT_REMOTE_FAULT] = remote_fault_indication;
  act_set[`PME_ACT_SYNC_LOSS] = sync_loss_indication;
end

////////////////////////////////////////////////////////////////////////////////
// APB decode

// Read data is captured one cycle before completion, so the clearing read
// only clears the bits software actually saw; newer events survive.
wire setup_acc = psel & penable & (state_ff == ST_WAIT);
wire complete = psel & penable & (state_ff == ST_DONE);
wire cpu_wr = complete & pwrite;
wire cpu_rd = complete & ~pwrite;
wire hit_pending = (paddr == `PME_OFS_PENDING);
wire hit_mask = (paddr == `PME_OFS_MASK);
wire hit_source = (paddr == `PME_OFS_SOURCE);
wire hit_activity = (paddr == `PME_OFS_ACTIVITY);
wire hit_err = (paddr == `PME_OFS_ERR_COUNTS);
wire hit_corrupt = (paddr == `PME_OFS_CORRUPT);
wire hit_jabber = (paddr == `PME_OFS_JABBER);
wire mapped = hit_pending | hit_mask | hit_source | hit_activity |
  hit_err | hit_corrupt | hit_jabber;

wire [`PME_EV_W-1:0] live_pending = pending_ff & ~mask_ff;
wire mac_source_pending = |live_pending;
wire [2:0] source_vec = {mac_source_pending, pcs_source_pending,
  serdes_source_pending};

always @* begin
  nxt_state = state_ff;
  case (state_ff)
    ST_IDLE: begin
      if (psel & ~penable) begin
        nxt_state = ST_WAIT;
      end
    end
    ST_WAIT: begin
      if (setup_acc) begin
        nxt_state = ST_DONE;
      end else if (~psel) begin
        nxt_state = ST_IDLE;
      end
    end
    ST_DONE: begin
      nxt_state = ST_IDLE;
    end
    default: begin
      nxt_state = ST_IDLE;
    end
  endcase
end

always @* begin
  nxt_ready = 1'b0;
  nxt_err = err_ff;
  nxt_rdata = rdata_ff;
  if (setup_acc) begin
    nxt_ready = 1'b1;
    nxt_err = ~mapped;
    nxt_rdata = 32'h00000000;
    if (~pwrite) begin
      if (hit_pending) begin
        nxt_rdata[`PME_EV_W-1:0] = pending_ff;
      end
      if (hit_mask) begin
        nxt_rdata[`PME_EV_W-1:0] = mask_ff;
      end
      if (hit_source) begin
        nxt_rdata[2:0] = source_vec;
      end
      if (hit_activity) begin
        nxt_rdata[`PME_ACT_W-1:0] = activity_ff;
      end
      if (hit_err) begin
        nxt_rdata[`PME_OVERFLOW_LSB +: CNT8_W] = ovf_cnt_ff;
        nxt_rdata[`PME_UNDERFLOW_LSB +: CNT8_W] = unf_cnt_ff;
      end
      if (hit_corrupt) begin
        nxt_rdata[CNT16_W-1:0] = corrupt_cnt_ff;
      end
      if (hit_jabber) begin
        nxt_rdata[CNT16_W-1:0] = jabber_cnt_ff;
      end
    end
  end else if (complete) begin
    nxt_err = 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pending events and mask

reg [`PME_EV_W-1:0] pend_clr;
always @* begin
  pend_clr = {`PME_EV_W{1'b0}};
  if (cpu_rd & hit_pending) begin
    pend_clr = rdata_ff[`PME_EV_W-1:0];
  end
  if (cpu_wr & hit_pending) begin
    pend_clr = pwdata[`PME_EV_W-1:0];
  end
  nxt_pending = (pending_ff & ~pend_clr) | ev_set;
  nxt_mask = mask_ff;
  if (cpu_wr & hit_mask) begin
    nxt_mask = pwdata[`PME_EV_W-1:0];
  end
  // Only MAC, PCS and SERDES sources reach the interrupt
  nxt_irq = |{(nxt_pending & ~nxt_mask), pcs_source_pending,
    serdes_source_pending};
end

////////////////////////////////////////////////////////////////////////////////
// Activity and link status

// The LED machine takes the whole register; the CPU clears what it read.
reg [`PME_ACT_W-1:0] act_clr;
always @* begin
  act_clr = {`PME_ACT_W{1'b0}};
  nxt_led = led_ff;
  if (led_read) begin
    act_clr = activity_ff;
    nxt_led = activity_ff;
  end
  if (cpu_rd & hit_activity) begin
    act_clr = act_clr | rdata_ff[`PME_ACT_W-1:0];
  end
  nxt_activity = (activity_ff & ~act_clr) | act_set;
end

////////////////////////////////////////////////////////////////////////////////
// Error counters

// Counters saturate rather than wrap, so a large count never reads as small
reg [CNT16_W-1:0] ovf_inc;
reg [CNT16_W-1:0] unf_inc;
always @* begin
  ovf_inc = sat_inc({{(CNT16_W-CNT8_W){1'b0}}, ovf_cnt_ff}, TOP8);
  unf_inc = sat_inc({{(CNT16_W-CNT8_W){1'b0}}, unf_cnt_ff}, TOP8);
  nxt_ovf_cnt = ovf_cnt_ff;
  nxt_unf_cnt = unf_cnt_ff;
  nxt_corrupt_cnt = corrupt_cnt_ff;
  nxt_jabber_cnt = jabber_cnt_ff;
  if (rx_overflow_discard_evt) begin
    nxt_ovf_cnt = ovf_inc[CNT8_W-1:0];
  end
  if (tx_underflow_frame_evt) begin
    nxt_unf_cnt = unf_inc[CNT8_W-1:0];
  end
  if (corrupted_frame_evt) begin
    nxt_corrupt_cnt = sat_inc(corrupt_cnt_ff, TOP16);
  end
  if (cpu_wr & hit_jabber) begin
    nxt_jabber_cnt = {CNT16_W{1'b0}};
  end
  if (jabber_evt) begin
    nxt_jabber_cnt = sat_inc(nxt_jabber_cnt, TOP16);
  end
end

////////////////////////////////////////////////////////////////////////////////
// State update

always @(posedge sys_clk) begin
  if (!nrst) begin
    state_ff <= ST_IDLE;
    pending_ff <= `PME_RST_PENDING;
    mask_ff <= `PME_RST_MASK;
    activity_ff <= `PME_RST_ACTIVITY;
    ovf_cnt_ff <= {CNT8_W{1'b0}};
    unf_cnt_ff <= {CNT8_W{1'b0}};
    corrupt_cnt_ff <= {CNT16_W{1'b0}};
    jabber_cnt_ff <= {CNT16_W{1'b0}};
    fab_en_d_ff <= 1'b0;
    pause_en_d_ff <= 1'b0;
    lost_seen_ff <= 1'b0;
    rdata_ff <= 32'h00000000;
    ready_ff <= 1'b0;
    err_ff <= 1'b0;
    irq_ff <= 1'b0;
    led_ff <= `PME_RST_ACTIVITY;
  end else begin
    state_ff <= nxt_state;
    pending_ff <= nxt_pending;
    mask_ff <= nxt_mask;
    activity_ff <= nxt_activity;
    ovf_cnt_ff <= nxt_ovf_cnt;
    unf_cnt_ff <= nxt_unf_cnt;
    corrupt_cnt_ff <= nxt_corrupt_cnt;
    jabber_cnt_ff <= nxt_jabber_cnt;
    fab_en_d_ff <= fabric_enable;
    pause_en_d_ff <= rx_pause_enable;
    lost_seen_ff <= nxt_lost_seen;
    rdata_ff <= nxt_rdata;
    ready_ff <= nxt_ready;
    err_ff <= nxt_err;
    irq_ff <= nxt_irq;
    led_ff <= nxt_led;
  end
end

endmodule // pme_event_status

`default_nettype wire

// ---- pme_event_status_props.sv ----
// Checker for the port event block, bound to its top module
// Assumes the register map header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "pme_map.vh"
////////////////////////////////////////////////////////////////////////////////
module pme_event_status_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pcs_source_pending,
  input wire logic serdes_source_pending,
  input wire logic tx_active,
  input wire logic link_up_indication,
  input wire logic led_read,
  input wire logic [`PME_ACT_W-1:0] led_status,
  input wire logic port_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_PCS_IRQ: assert property (pcs_source_pending |=> port_irq)
    else $error("irq missing for pcs");
  AST_SERDES_IRQ: assert property (serdes_source_pending |=> port_irq)
    else $error("irq missing for serdes");
  // Past reset guards the latch, which was held clear while reset was low
  AST_LED_TX: assert property (led_read && $past(tx_active) && $past(nrst) |=> led_status[4])
    else $error("transmit activity lost");
  AST_LED_LINK: assert property ($past(nrst) && $past(link_up_indication) ##0 led_read
    |=> led_status[2])
    else $error("link activity lost");
  AST_LED_HOLD: assert property (!led_read |=> $stable(led_status))
    else $error("led snapshot moved without read");
  AST_PEND_UPPER: assert property (pready && !pwrite && paddr == `PME_OFS_PENDING
    |-> prdata[31:11] == 21'h0)
    else $error("pending upper bits set");
  AST_MASK_UPPER: assert property (pready && !pwrite && paddr == `PME_OFS_MASK
    |-> prdata[31:11] == 21'h0)
    else $error("mask upper bits set");
  AST_SRC_UPPER: assert property (pready && !pwrite && paddr == `PME_OFS_SOURCE
    |-> prdata[31:3] == 29'h0)
    else $error("source upper bits set");
  AST_CNT_UPPER: assert property (pready && !pwrite && paddr == `PME_OFS_ERR_COUNTS
    |-> prdata[31:16] == 16'h0)
    else $error("count upper bits set");
endmodule // pme_event_status_chk
////////////////////////////////////////////////////////////////////////////////
bind pme_event_status pme_event_status_chk u_chk (.sys_clk, .nrst, .pwrite, .paddr, .prdata,
  .pready, .pcs_source_pending, .serdes_source_pending, .tx_active, .link_up_indication,
  .led_read, .led_status, .port_irq);
`default_nettype wire

// ---- pme_map.vh ----
// Register map, field positions and reset values for the port event block
// Assumes inclusion by bare name from the design file
`ifndef PME_MAP_VH
`define PME_MAP_VH

// Byte offsets of the APB registers
`define PME_OFS_PENDING 8'h00
`define PME_OFS_MASK 8'h04
`define PME_OFS_SOURCE 8'h08
`define PME_OFS_ACTIVITY 8'h0C
`define PME_OFS_ERR_COUNTS 8'h10
`define PME_OFS_CORRUPT 8'h14
`define PME_OFS_JABBER 8'h18

// Event bit positions in pending and mask registers
`define PME_EV_RUNT 0
`define PME_EV_OVERFLOW 1
`define PME_EV_RX_CRC 2
`define PME_EV_OVERSIZED 3
`define PME_EV_PAUSE_OVF 4
`define PME_EV_PHY_ERR 5
`define PME_EV_TX_CRC 6
`define PME_EV_TX_ONLY_CRC 7
`define PME_EV_TX_UNDERFLOW 8
`define PME_EV_PAUSE_DROP 9
`define PME_EV_FABRIC 10
`define PME_EV_W 11

// Source register bit positions
`define PME_SRC_SERDES 0
`define PME_SRC_PCS 1
`define PME_SRC_MAC 2

// Activity and link status bit positions
`define PME_ACT_SYNC_LOSS 0
`define PME_ACT_REMOTE_FAULT 1
`define PME_ACT_LINK_UP 2
`define PME_ACT_RECEIVING 3
`define PME_ACT_TRANSMITTING 4
`define PME_ACT_W 5

// Error count field positions
`define PME_UNDERFLOW_LSB 0
`define PME_OVERFLOW_LSB 8

// Reset values
`define PME_RST_PENDING 11'h000
`define PME_RST_MASK 11'h7FF
`define PME_RST_ACTIVITY 5'h00

`endif

// ---- tb.sv ----
// Self-checking bench for the port event block
// Assumes one 100 MHz clock and the register map header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "pme_map.vh"
////////////////////////////////////////////////////////////////////////////////
module tb;
  localparam logic [7:0] PND = `PME_OFS_PENDING;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, se, port_irq, led_read = 1'b0, fe = 1'b1, pe = 1'b1;
  logic crx = 1'b0, bad = 1'b0, pcs = 1'b0, ser = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] pu = 12'h000;
  logic [4:0] act = 5'h00, led_status;
  logic [15:0] len = 16'h0000, maxl = 16'h0064;
  int err_count = 0, checked = 0;
  always #5 sys_clk = ~sys_clk;
  pme_event_status dut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fabric_enable(fe), .rx_pause_enable(pe), .tx_underflow_evt(pu[0]),
    .tx_crc_err_evt(pu[1]), .tx_crc_from_rx(crx), .rx_phy_err_evt(pu[2]),
    .pause_overflow_evt(pu[3]), .rx_crc_err_evt(pu[4]), .rx_runt_evt(pu[5]),
    .rx_frame_start(pu[6]), .rx_word_lost_evt(pu[7]), .rx_frame_end(pu[8]),
    .rx_frame_len(len), .rx_frame_crc_bad(bad), .max_frame_length(maxl),
    .rx_overflow_discard_evt(pu[9]), .tx_underflow_frame_evt(pu[10]),
    .corrupted_frame_evt(pu[11]), .pcs_source_pending(pcs), .serdes_source_pending(ser),
    .tx_active(act[4]), .receiving_indication(act[3]), .link_up_indication(act[2]),
    .remote_fault_indication(act[1]), .sync_loss_indication(act[0]), .led_read,
    .led_status, .port_irq);
  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Ends one idle edge after release so no signal is driven twice in a step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 50) begin
      err_count++;
      complete_run();
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, e);
  endtask
  task pulse(input logic [11:0] m);
    pu <= m;
    @(posedge sys_clk);
    pu <= 12'h000;
    @(posedge sys_clk);
  endtask
  task ci(input logic e);
    check("irq", {31'h0, port_irq}, {31'h0, e});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(PND, 32'h0);
    rdc(`PME_OFS_MASK, 32'h7FF);
    rdc(`PME_OFS_SOURCE, 32'h0);
    rdc(`PME_OFS_ACTIVITY, 32'h0);
    rdc(`PME_OFS_ERR_COUNTS, 32'h0);
    rdc(`PME_OFS_CORRUPT, 32'h0);
    rdc(`PME_OFS_JABBER, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped", {31'h0, se}, 32'h1);
    $display("reset test done");
  endtask
  task t_events;
    logic [10:0] xp [6];
    xp = '{11'h100, 11'h0C0, 11'h020, 11'h010, 11'h004, 11'h001};
    for (int i = 0; i < 6; i++) begin
      pulse(12'h001 << i);
      rdc(PND, {21'h0, xp[i]});
    end
    crx <= 1'b1;
    pulse(12'h002);
    rdc(PND, 32'h040);
    crx <= 1'b0;
    fe <= 1'b0;
    pe <= 1'b0;
    tick(2);
    rdc(PND, 32'h600);
    fe <= 1'b1;
    pe <= 1'b1;
    pulse(12'h040);
    pulse(12'h080);
    pulse(12'h080);
    rdc(PND, 32'h002);
    pulse(12'h080);
    rdc(PND, 32'h0);
    pulse(12'h040);
    pulse(12'h080);
    rdc(PND, 32'h002);
    $display("event test done");
  endtask
  task t_irq;
    pulse(12'h020);
    tick(2);
    ci(1'b0);
    apb(1'b1, `PME_OFS_MASK, 32'h7FE);
    tick(1);
    ci(1'b1);
    rdc(`PME_OFS_SOURCE, 32'h4);
    rdc(PND, 32'h1);
    tick(2);
    ci(1'b0);
    act <= 5'h1F;
    tick(3);
    ci(1'b0);
    act <= 5'h00;
    pcs <= 1'b1;
    tick(2);
    ci(1'b1);
    rdc(`PME_OFS_SOURCE, 32'h2);
    pcs <= 1'b0;
    ser <= 1'b1;
    tick(2);
    rdc(`PME_OFS_SOURCE, 32'h1);
    ser <= 1'b0;
    apb(1'b1, `PME_OFS_MASK, 32'h7FF);
    rdc(`PME_OFS_ACTIVITY, 32'h1F);
    rdc(`PME_OFS_ACTIVITY, 32'h0);
    act <= 5'h15;
    tick(1);
    act <= 5'h00;
    led_read <= 1'b1;
    tick(1);
    led_read <= 1'b0;
    tick(1);
    check("led", {27'h0, led_status}, 32'h15);
    rdc(`PME_OFS_ACTIVITY, 32'h0);
    $display("irq and activity test done");
  endtask
  task t_count;
    logic d;
    for (int i = 0; i < 6; i++) pulse(i < 2 ? 12'h200 : (i < 5 ? 12'h400 : 12'h800));
    apb(1'b1, `PME_OFS_ERR_COUNTS, 32'hFFFF);
    rdc(`PME_OFS_ERR_COUNTS, 32'h0203);
    rdc(`PME_OFS_CORRUPT, 32'h1);
    len <= 16'h0065;
    bad <= 1'b1;
    pulse(12'h100);
    len <= 16'h0064;
    pulse(12'h100);
    len <= 16'h0065;
    bad <= 1'b0;
    pulse(12'h100);
    rdc(`PME_OFS_JABBER, 32'h1);
    rdc(PND, 32'h008);
    apb(1'b1, `PME_OFS_JABBER, 32'h1234);
    rdc(`PME_OFS_JABBER, 32'h0);
    // Event repeats on the clearing edge of a read that saw it; it must survive
    pulse(12'h001);
    fork
      apb(1'b0, PND, 32'h0);
      begin
        tick(2);
        pulse(12'h001);
      end
    join
    d = rd[8];
    apb(1'b0, PND, 32'h0);
    check("late event", {31'h0, d & rd[8]}, 32'h1);
    $display("count test done");
  endtask
  initial begin
    tick(8);
    nrst <= 1'b1;
    tick(1);
    t_reset();
    t_events();
    t_irq();
    t_count();
    complete_run();
  end
endmodule // tb
`default_nettype wire
